// ===== logic/scppk_pkg.sv
// constants for the serial control port with peak readout
package scppk_pkg;
   // ************************************************************
   // address byte layout
   // ************************************************************
   localparam int          SCPPK_BYTE_W     = 8;
   localparam int          SCPPK_DEV_MSB    = 7;
   localparam int          SCPPK_DEV_LSB    = 2;
   localparam logic [5:0]  SCPPK_DEV_ADDR   = 6'h2A; // arbitrary value
   // transfer type codes
   localparam logic [1:0]  SCPPK_TYPE_SOUND = 2'h0;
   localparam logic [1:0]  SCPPK_TYPE_PEAK  = 2'h1;
   localparam logic [1:0]  SCPPK_TYPE_STAT  = 2'h2;
   // ************************************************************
   // write byte selectors
   // ************************************************************
   localparam logic [1:0]  SCPPK_SEL_VOL    = 2'h0;
   localparam logic [1:0]  SCPPK_SEL_BASS   = 2'h1;
   localparam logic [1:0]  SCPPK_SEL_POS    = 2'h2;
   localparam logic [2:0]  SCPPK_SEL_EXTA   = 3'h6;
   localparam logic [2:0]  SCPPK_SEL_EXTV   = 3'h7;
   localparam int          SCPPK_POS_BIT    = 5;
   localparam int          SCPPK_RST_BIT    = 6;
   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [6:0]  SCPPK_STAT0_RST  = 7'h00;
   localparam logic [6:0]  SCPPK_STAT1_RST  = 7'h00;
   localparam logic [1:0]  SCPPK_CLKSEL_RST = 2'h0;
   localparam logic [5:0]  SCPPK_D6_RST     = 6'h00;
   localparam logic        SCPPK_POS_RST    = 1'b1; // after tone
   localparam logic [2:0]  SCPPK_EXTA_RST   = 3'h0;
   localparam logic [4:0]  SCPPK_EXTV_RST   = 5'h00;
   localparam logic [7:0]  SCPPK_PEAK_RST   = 8'h00;
   localparam int          SCPPK_EXT_N      = 8;
endpackage : scppk_pkg

// ===== logic/scppk_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module scppk_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // pin and filtered level
   input  wire logic pin,
   output logic      level
);
   import scppk_pkg::*;
   logic [2:0] stage_reg;
   logic [2:0] stage_next;
   logic       level_reg;
   logic       level_next;

   // ************************************************************
   // change accepted once stages two and three agree
   // ************************************************************
   always_comb begin
      stage_next = {stage_reg[1:0], pin};
      level_next = level_reg;
      if (stage_reg[1] == stage_reg[2]) begin
         level_next = stage_reg[2];
      end
   end

   // register stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // lines rest high, so start there to avoid a false edge
         stage_reg <= '1;
         level_reg <= 1'b1;
      end else begin
         stage_reg <= stage_next;
         level_reg <= level_next;
      end
   end
   assign level = level_reg;
endmodule : scppk_sync

// ===== logic/scppk_port.sv
// serial control port with peak-hold readout
`timescale 1ns/100ps
module scppk_port #(
   parameter int LEVEL_W = 8
) (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // serial control pins
   input  wire logic               ctl_phase_line,
   input  wire logic               ctl_serial_clock,
   input  wire logic               ctl_serial_data_in,
   output logic                    ctl_serial_data_out,
   output logic                    ctl_serial_data_oe_n,
   // playback levels, pre and post tone
   input  wire logic [LEVEL_W-1:0] level_pre,
   input  wire logic [LEVEL_W-1:0] level_post,
   input  wire logic               level_valid,
   // settings
   output logic [6:0]              status_cfg0,
   output logic [1:0]              clock_rate_sel,
   output logic [6:0]              status_cfg1,
   output logic [5:0]              volume_set,
   output logic [5:0]              bass_treble_set,
   output logic                    peak_position_select,
   output logic [4:0]              mode_set,
   output logic [2:0]              extended_addr_reg,
   output logic [4:0]              extended_value_reg,
   output logic                    ext_write,
   output logic                    selected
);
   import scppk_pkg::*;

   typedef enum logic [2:0] {
      SCPPK_IDLE = 3'b001,
      SCPPK_ADDR = 3'b010,
      SCPPK_DATA = 3'b100
   } scppk_state_t;

   logic [2:0] pin_raw;
   logic [2:0] pin_sync;
   logic       mode_s;
   logic       sclk_s;
   logic       sdat_s;
   assign pin_raw = {ctl_phase_line, ctl_serial_clock, ctl_serial_data_in};
   // one filtered synchroniser per pin
   for (genvar g = 0; g < 3; g++) begin : g_sync
      scppk_sync u_sync (
         .clk   (clk),
         .rst   (rst),
         .pin   (pin_raw[g]),
         .level (pin_sync[g])
      );
   end
   assign mode_s = pin_sync[2];
   assign sclk_s = pin_sync[1];
   assign sdat_s = pin_sync[0];

   // ************************************************************
   // state
   // ************************************************************
   scppk_state_t       st_reg, st_next;
   logic               sclk_d_reg, mode_d_reg;
   logic [2:0]         cnt_reg, cnt_next;
   logic [7:0]         sh_reg, sh_next;
   logic               sel_reg, sel_next;
   logic [1:0]         typ_reg, typ_next;
   logic [6:0]         st0_reg, st0_next, st1_reg, st1_next;
   logic [1:0]         clk_reg, clk_next;
   logic [5:0]         vol_reg, vol_next, bt_reg, bt_next;
   logic               pos_reg, pos_next;
   logic [4:0]         md_reg, md_next;
   logic [2:0]         ea_reg, ea_next;
   logic [4:0]         ev_reg, ev_next;
   logic               ew_reg, ew_next;
   logic [LEVEL_W-1:0] pk_reg, pk_next, pks_reg, pks_next;
   logic               do_reg, do_next, oe_n_reg, oe_n_next;

   wire rise = sclk_s & ~sclk_d_reg;
   wire fall = ~sclk_s & sclk_d_reg;
   wire last = (cnt_reg == 3'h7);
   wire [7:0] byte_in = {sh_reg[6:0], sdat_s};

   // is this address byte ours
   function automatic logic own_addr(input logic [7:0] b);
      return b[SCPPK_DEV_MSB:SCPPK_DEV_LSB] == SCPPK_DEV_ADDR;
   endfunction : own_addr

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb begin
      logic [LEVEL_W-1:0] lvl;
      lvl = pos_reg ? level_post : level_pre;
      st_next = st_reg; cnt_next = cnt_reg; sh_next = sh_reg;
      sel_next = sel_reg; typ_next = typ_reg;
      st0_next = st0_reg; st1_next = st1_reg; clk_next = clk_reg;
      vol_next = vol_reg; bt_next = bt_reg; pos_next = pos_reg;
      md_next = md_reg; ea_next = ea_reg; ev_next = ev_reg;
      ew_next = 1'b0; pk_next = pk_reg; pks_next = pks_reg;
      do_next = do_reg; oe_n_next = oe_n_reg;
      // peak hold, only grows
      if (level_valid && lvl > pk_reg) begin
         pk_next = lvl;
      end
      // mode edge restarts bit framing
      if (mode_s != mode_d_reg) begin
         cnt_next = 3'h0;
         st_next = mode_s ? SCPPK_DATA : SCPPK_ADDR;
         oe_n_next = 1'b1;
         pks_next = pk_next;
      end else if (rise && st_reg != SCPPK_IDLE) begin
         sh_next = byte_in;
         cnt_next = cnt_reg + 3'h1;
         if (last && st_reg == SCPPK_ADDR) begin
            sel_next = own_addr(byte_in);
            typ_next = byte_in[1:0];
         end else if (last && sel_reg) begin
            case (typ_reg)
               SCPPK_TYPE_SOUND: begin
                  if (byte_in[7:5] == SCPPK_SEL_EXTA) begin
                     ea_next = byte_in[2:0];
                  end else if (byte_in[7:5] == SCPPK_SEL_EXTV) begin
                     ev_next = byte_in[4:0];
                     ew_next = 1'b1;
                  end else if (byte_in[7:6] == SCPPK_SEL_VOL) begin
                     vol_next = byte_in[5:0];
                  end else if (byte_in[7:6] == SCPPK_SEL_BASS) begin
                     bt_next = byte_in[5:0];
                  end else if (byte_in[7:6] == SCPPK_SEL_POS) begin
                     pos_next = byte_in[SCPPK_POS_BIT];
                     md_next = byte_in[4:0];
                  end else begin
                     md_next = byte_in[4:0];
                  end
               end
               SCPPK_TYPE_PEAK: begin
                  // a sample landing with the clear starts the new hold
                  pk_next = level_valid ? lvl
                                        : LEVEL_W'(SCPPK_PEAK_RST);
                  pks_next = pk_next;
                  oe_n_next = 1'b1;
               end
               SCPPK_TYPE_STAT: begin
                  if (byte_in[7]) begin
                     st1_next = byte_in[6:0];
                  end else if (byte_in[SCPPK_RST_BIT]) begin
                     st0_next = SCPPK_STAT0_RST;
                     st1_next = SCPPK_STAT1_RST;
                     vol_next = SCPPK_D6_RST;
                     bt_next = SCPPK_D6_RST;
                     pos_next = SCPPK_POS_RST;
                     md_next = SCPPK_EXTV_RST;
                     ea_next = SCPPK_EXTA_RST;
                     ev_next = SCPPK_EXTV_RST;
                     clk_next = byte_in[5:4];
                  end else begin
                     st0_next = byte_in[6:0];
                     clk_next = byte_in[5:4];
                  end
               end
               default: begin
               end
            endcase
         end
      end else if (fall && st_reg == SCPPK_DATA && sel_reg &&
                   typ_reg == SCPPK_TYPE_PEAK) begin
         do_next = pks_reg[LEVEL_W-1-cnt_reg];
         oe_n_next = 1'b0;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // edge detectors start at the lines' resting level
         st_reg <= SCPPK_IDLE; sclk_d_reg <= 1'b1; mode_d_reg <= 1'b1;
         cnt_reg <= 3'h0; sh_reg <= 8'h00; sel_reg <= 1'b0;
         typ_reg <= 2'h3; st0_reg <= SCPPK_STAT0_RST;
         st1_reg <= SCPPK_STAT1_RST; clk_reg <= SCPPK_CLKSEL_RST;
         vol_reg <= SCPPK_D6_RST; bt_reg <= SCPPK_D6_RST;
         pos_reg <= SCPPK_POS_RST; md_reg <= SCPPK_EXTV_RST;
         ea_reg <= SCPPK_EXTA_RST; ev_reg <= SCPPK_EXTV_RST;
         ew_reg <= 1'b0; pk_reg <= '0; pks_reg <= '0;
         do_reg <= 1'b0; oe_n_reg <= 1'b1;
      end else begin
         st_reg <= st_next; sclk_d_reg <= sclk_s; mode_d_reg <= mode_s;
         cnt_reg <= cnt_next; sh_reg <= sh_next; sel_reg <= sel_next;
         typ_reg <= typ_next; st0_reg <= st0_next; st1_reg <= st1_next;
         clk_reg <= clk_next; vol_reg <= vol_next; bt_reg <= bt_next;
         pos_reg <= pos_next; md_reg <= md_next; ea_reg <= ea_next;
         ev_reg <= ev_next; ew_reg <= ew_next; pk_reg <= pk_next;
         pks_reg <= pks_next; do_reg <= do_next; oe_n_reg <= oe_n_next;
      end
   end

   // outputs straight from flops
   assign ctl_serial_data_out  = do_reg;
   assign ctl_serial_data_oe_n = oe_n_reg;
   assign status_cfg0 = st0_reg;
   assign clock_rate_sel = clk_reg;
   assign status_cfg1 = st1_reg;
   assign volume_set = vol_reg;
   assign bass_treble_set = bt_reg;
   assign peak_position_select = pos_reg;
   assign mode_set = md_reg;
   assign extended_addr_reg = ea_reg;
   assign extended_value_reg = ev_reg;
   assign ext_write = ew_reg;
   assign selected = sel_reg;

   // ************************************************************
   // checks
   // ************************************************************
   // eighth address bit, no mode edge in the same cycle
   sequence s_addr_done;
      st_reg == SCPPK_ADDR && rise && last && mode_s == mode_d_reg;
   endsequence
   // eighth bit of a peak readout byte
   sequence s_peak_done;
      st_reg == SCPPK_DATA && rise && last && sel_reg
      && mode_s == mode_d_reg && typ_reg == SCPPK_TYPE_PEAK;
   endsequence
   a_foreign_deselect: assert property (
      @(posedge clk) disable iff (rst)
      s_addr_done ##0 !own_addr(byte_in) |=> !sel_reg)
      else $error("foreign address kept selection");
   a_own_select: assert property (
      @(posedge clk) disable iff (rst)
      s_addr_done ##0 own_addr(byte_in)
      |=> sel_reg && typ_reg == $past(byte_in[1:0]))
      else $error("own address not selected");
   a_drive_only_peak: assert property (
      @(posedge clk) disable iff (rst)
      !oe_n_reg |-> sel_reg && typ_reg == SCPPK_TYPE_PEAK)
      else $error("data driven outside peak readout");
   a_line_released: assert property (
      @(posedge clk) disable iff (rst)
      s_peak_done |=> oe_n_reg)
      else $error("data line held after peak byte");
   a_peak_never_drop: assert property (
      @(posedge clk) disable iff (rst)
      mode_s == mode_d_reg && !rise |=> pk_reg >= $past(pk_reg))
      else $error("peak decreased without readout");
   a_peak_clear: assert property (
      @(posedge clk) disable iff (rst)
      s_peak_done ##0 !level_valid |=> pk_reg == '0)
      else $error("peak not cleared after readout");
   a_clock_kept: assert property (
      @(posedge clk) disable iff (rst)
      $changed(clk_reg) |-> $past(typ_reg) == SCPPK_TYPE_STAT
      && $past(sel_reg) && !$past(sh_reg[6]))
      else $error("clock rate changed unexpectedly");
   a_ext_commit: assert property (
      @(posedge clk) disable iff (rst)
      ew_reg |-> typ_reg == SCPPK_TYPE_SOUND && sel_reg)
      else $error("extended write outside sound group");
   a_unused_ignored: assert property (
      @(posedge clk) disable iff (rst)
      typ_reg == 2'h3 |=> $stable(st0_reg) && $stable(vol_reg))
      else $error("unused type changed settings");
endmodule : scppk_port

// ===== verif/scppk_host.sv
// behavioural controller model for the serial control port
`timescale 1ns/100ps
module scppk_host (
   // pins driven by the controller
   output logic      ctl_phase_line,
   output logic      ctl_serial_clock,
   output logic      ctl_serial_data_in,
   // device side of the shared data line
   input  wire logic ctl_serial_data_out,
   input  wire logic ctl_serial_data_oe_n
);
   // ************************************************************
   // bus timing and line state
   // ************************************************************
   localparam time HALF = 80ns;
   logic drive;
   logic bit_val;
   // wire level: a released, undriven line shows the inverted last bit
   assign ctl_serial_data_in = !ctl_serial_data_oe_n ? ctl_serial_data_out
      : (drive ? bit_val : ~bit_val);
   // clock stands high between frames
   initial begin
      ctl_phase_line   = 1'b1;
      ctl_serial_clock = 1'b1;
      drive            = 1'b1;
      bit_val          = 1'b0;
   end
   // one byte, msb first; data moves after the falling edge
   task automatic shift(input logic [7:0] tx, input logic rd,
                        output logic [7:0] rx);
      drive = !rd;
      for (int i = 7; i >= 0; i--) begin
         ctl_serial_clock = 1'b0;
         bit_val          = tx[i];
         #HALF;
         ctl_serial_clock = 1'b1;
         rx[i]            = ctl_serial_data_in;
         #HALF;
      end
      drive = 1'b1;
   endtask : shift
   // address phase, mode low for exactly eight bits
   task automatic address(input logic [7:0] adr);
      logic [7:0] unused;
      ctl_phase_line = 1'b0;
      #HALF;
      shift(adr, 1'b0, unused);
      ctl_phase_line = 1'b1;
      #HALF;
   endtask : address
   // whole write byte in the data phase
   task automatic put(input logic [7:0] dat);
      logic [7:0] unused;
      shift(dat, 1'b0, unused);
   endtask : put
   // peak byte, line released to the device
   task automatic get(output logic [7:0] dat);
      shift(8'h00, 1'b1, dat);
   endtask : get
endmodule : scppk_host

// ===== verif/test_scppk_port.sv
// self-checking bench for the serial control port
`timescale 1ns/100ps
module test_scppk_port;
   import scppk_pkg::*;
   // ************************************************************
   // rows and signals
   // ************************************************************
   typedef struct packed {
      logic [7:0]  adr;
      logic [7:0]  dat;
      logic [31:0] d0;
      logic [31:0] st;
   } scppk_row_t;
   localparam logic [7:0] A_SND = {SCPPK_DEV_ADDR, SCPPK_TYPE_SOUND};
   localparam logic [7:0] A_PK  = {SCPPK_DEV_ADDR, SCPPK_TYPE_PEAK};
   localparam logic [7:0] A_ST  = {SCPPK_DEV_ADDR, SCPPK_TYPE_STAT};
   localparam logic [7:0] A_NU  = {SCPPK_DEV_ADDR, 2'h3};
   localparam logic [7:0] A_FR  = {~SCPPK_DEV_ADDR, SCPPK_TYPE_SOUND};
   // each row: address byte, data byte, settings and status after it
   scppk_row_t rows [10] = '{
      '{A_SND, 8'h15, 32'h1500_8000, 32'h0000_0000},
      '{A_SND, 8'h6A, 32'h152A_8000, 32'h0000_0000},
      '{A_SND, 8'h83, 32'h152A_0300, 32'h0000_0000},
      '{A_SND, 8'hC5, 32'h152A_03A0, 32'h0000_0000},
      '{A_SND, 8'hFB, 32'h152A_03BB, 32'h0000_0000},
      '{A_ST,  8'h2D, 32'h152A_03BB, 32'h002D_0002},
      '{A_ST,  8'hC3, 32'h152A_03BB, 32'h002D_4302},
      '{A_NU,  8'h3F, 32'h152A_03BB, 32'h002D_4302},
      '{A_FR,  8'h00, 32'h152A_03BB, 32'h002D_4302},
      '{A_SND, 8'h00, 32'h002A_03BB, 32'h002D_4302}
   };
   logic        clk = 1'b0;
   logic        rst;
   logic [7:0]  level_pre;
   logic [7:0]  level_post;
   logic        level_valid;
   logic        ctl_phase_line;
   logic        ctl_serial_clock;
   logic        ctl_serial_data_in;
   logic        ctl_serial_data_out;
   logic        ctl_serial_data_oe_n;
   logic [6:0]  status_cfg0;
   logic [1:0]  clock_rate_sel;
   logic [6:0]  status_cfg1;
   logic [5:0]  volume_set;
   logic [5:0]  bass_treble_set;
   logic        peak_position_select;
   logic [4:0]  mode_set;
   logic [2:0]  extended_addr_reg;
   logic [4:0]  extended_value_reg;
   logic        ext_write;
   logic        selected;
   logic [7:0]  rd_val;
   logic [31:0] d0;
   logic [31:0] st;
   int          fail_count = 0;
   int          n_compared = 0;
   int          ext_count  = 0;
   // packed views of the settings for whole-word compares
   assign d0 = {2'b00, volume_set, 2'b00, bass_treble_set,
                peak_position_select, 2'b00, mode_set,
                extended_addr_reg, extended_value_reg};
   assign st = {8'h00, 1'b0, status_cfg0, 1'b0, status_cfg1,
                6'h00, clock_rate_sel};
   // ************************************************************
   // design and controller model
   // ************************************************************
   scppk_port i_scppk_port (.clk(clk), .rst(rst),
      .ctl_phase_line(ctl_phase_line), .ctl_serial_clock(ctl_serial_clock),
      .ctl_serial_data_in(ctl_serial_data_in),
      .ctl_serial_data_out(ctl_serial_data_out),
      .ctl_serial_data_oe_n(ctl_serial_data_oe_n),
      .level_pre(level_pre), .level_post(level_post),
      .level_valid(level_valid), .status_cfg0(status_cfg0),
      .clock_rate_sel(clock_rate_sel), .status_cfg1(status_cfg1),
      .volume_set(volume_set), .bass_treble_set(bass_treble_set),
      .peak_position_select(peak_position_select), .mode_set(mode_set),
      .extended_addr_reg(extended_addr_reg),
      .extended_value_reg(extended_value_reg),
      .ext_write(ext_write), .selected(selected));
   scppk_host i_scppk_host (.ctl_phase_line(ctl_phase_line),
      .ctl_serial_clock(ctl_serial_clock),
      .ctl_serial_data_in(ctl_serial_data_in),
      .ctl_serial_data_out(ctl_serial_data_out),
      .ctl_serial_data_oe_n(ctl_serial_data_oe_n));
   // 250 MHz clock
   always #2ns clk = ~clk;
   // count extended write strobes; a stuck strobe shows as many
   // sampled off the edge that launches the strobe
   always @(negedge clk) begin
      if (ext_write === 1'b1) begin
         ext_count++;
      end
   end
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // one sample strobe with both playback levels
   task automatic lvl(input logic [7:0] pre, input logic [7:0] post);
      @(negedge clk);
      level_pre   = pre;
      level_post  = post;
      level_valid = 1'b1;
      @(negedge clk);
      level_valid = 1'b0;
   endtask : lvl
   task automatic results;
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : results
   // hang guard
   initial begin
      #200us;
      fail_count++;
      results();
   end
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      rst         = 1'b1;
      level_pre   = 8'h00;
      level_post  = 8'h00;
      level_valid = 1'b0;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (8) @(negedge clk);
      cmp(d0, 32'h0000_8000);
      cmp(st, 32'h0);
      cmp({31'h0, ctl_serial_data_oe_n}, 32'h1);
      foreach (rows[i]) begin
         i_scppk_host.address(rows[i].adr);
         i_scppk_host.put(rows[i].dat);
         cmp(d0, rows[i].d0);
         cmp(st, rows[i].st);
         if (i == 8) cmp({31'h0, selected}, 32'h0);
      end
      // several bytes in one data phase
      i_scppk_host.address(A_SND);
      i_scppk_host.put(8'h01);
      i_scppk_host.put(8'h42);
      cmp(d0, 32'h0102_03BB);
      // pre-tone peak held, then cleared by the readout
      lvl(8'h30, 8'h77);
      lvl(8'h55, 8'h10);
      lvl(8'h20, 8'h66);
      i_scppk_host.address(A_PK);
      i_scppk_host.get(rd_val);
      cmp({24'h0, rd_val}, 32'h55);
      cmp({31'h0, ctl_serial_data_oe_n}, 32'h1);
      i_scppk_host.address(A_PK);
      i_scppk_host.get(rd_val);
      cmp({24'h0, rd_val}, 32'h0);
      // move detector behind the tone stage
      i_scppk_host.address(A_SND);
      cmp({31'h0, ctl_serial_data_oe_n}, 32'h1);
      i_scppk_host.put(8'hA0);
      lvl(8'h30, 8'h77);
      lvl(8'h55, 8'h10);
      i_scppk_host.address(A_PK);
      i_scppk_host.get(rd_val);
      cmp({24'h0, rd_val}, 32'h77);
      // status reset keeps only the new clock rate
      i_scppk_host.address(A_ST);
      i_scppk_host.put(8'h60);
      cmp(d0, 32'h0000_8000);
      cmp({30'h0, clock_rate_sel}, 32'h2);
      cmp(st, 32'h0000_0002);
      cmp(32'(ext_count), 32'h1);
      // reset in mid-run; data with no address since is refused
      @(negedge clk);
      rst = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (8) @(negedge clk);
      cmp({31'h0, selected}, 32'h0);
      i_scppk_host.put(8'h15);
      cmp(d0, 32'h0000_8000);
      cmp(st, 32'h0);
      results();
   end
endmodule : test_scppk_port
